// File: src/mad_pkg.sv
/*
 * Package of the modem auto-dial command handler: register offsets,
 * command codes, option bit positions, timing constants and types.
 * Assumes a 50 MHz system clock and a 32-bit APB register bus.
 */
package mad_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned SEC_NS         = 1_000_000_000;
   localparam int unsigned SEC_CYCLES     = SEC_NS / CLK_PERIOD_NS;
   localparam int unsigned COMMA_PAUSE_S  = 2;
   localparam logic [15:0] DIAL_TMO_DEF_S = 16'h001e;
   localparam logic [15:0] CMD_TMO_DEF_S  = 16'h0009;

   // ==========================================================
   // Table values and command codes
   localparam logic [15:0] SIGNATURE  = 16'h4154;
   localparam logic [15:0] CMD_CREATE = 16'h0001;
   localparam logic [15:0] CMD_WRITE  = 16'h0201;
   localparam logic [15:0] CMD_HANGUP = 16'h0402;
   localparam logic [15:0] OPT_MODEM  = 16'h0001;
   localparam logic [3:0]  MAX_RINGS  = 4'h9;
   localparam logic [7:0]  CHAR_QUOTE = 8'h22;
   localparam logic [7:0]  CHAR_COMMA = 8'h2c;

   // Option bits are numbered 1 (msb) to 16 (lsb)
   localparam int unsigned OPT_BUSY_OFF_BIT = 16 - 14;
   localparam int unsigned OPT_TONE_OFF_BIT = 16 - 15;
   localparam int unsigned OPT_PULSE_BIT    = 16 - 16;

   // ==========================================================
   // Error codes (values arbitrary, all nonzero)
   localparam logic [15:0] ERR_BAD_SIG   = 16'h0101;
   localparam logic [15:0] ERR_BAD_CONN  = 16'h0102;
   localparam logic [15:0] ERR_BAD_CMD   = 16'h0103;
   localparam logic [15:0] ERR_NO_LINE   = 16'h0104;
   localparam logic [15:0] ERR_DIAL_FAIL = 16'h0105;
   localparam logic [15:0] ERR_CMD_TMO   = 16'h0106;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] REG_CMD_CODE = 12'h000;
   localparam logic [11:0] REG_CMD_CONN = 12'h004;
   localparam logic [11:0] REG_CMD_TMO  = 12'h008;
   localparam logic [11:0] REG_CMD_TRIG = 12'h00c;
   localparam logic [11:0] REG_CMD_ERR  = 12'h010;
   localparam logic [11:0] REG_STATUS   = 12'h014;
   localparam logic [11:0] REG_TBL_SIG  = 12'h018;
   localparam logic [11:0] REG_TBL_RING = 12'h01c;
   localparam logic [11:0] REG_TBL_AUTO = 12'h020;
   localparam logic [11:0] REG_TBL_OPT  = 12'h024;
   localparam logic [11:0] REG_TBL_HUP  = 12'h028;
   localparam logic [11:0] REG_TBL_DTMO = 12'h02c;
   localparam logic [11:0] REG_CONN_OPT = 12'h030;
   localparam logic [11:0] REG_DIAL_STR = 12'h040;
   localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

   // ==========================================================
   // Types
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_DIAL  = 6'b000010,
      ST_PAUSE = 6'b000100,
      ST_WAITC = 6'b001000,
      ST_XFER  = 6'b010000,
      ST_LINE  = 6'b100000
   } madState_e;

   typedef struct packed {
      logic       offHook;
      logic       pulseDial;
      logic       busyDetOff;
      logic       toneDetOff;
      logic [3:0] answerRings;
   } madModemCtl_s;

endpackage : mad_pkg

// File: src/mad_autodial.sv
/*
 * Modem auto-dial command handler: APB register file holding the modem
 * configuration table, dial string and command block, plus the dial,
 * time-out and hang-up sequencing.
 * Assumes the modem data path reports carrier, dial failures and each
 * character on the line; the transfer itself is done by that path.
 */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module mad_autodial #(
   parameter int unsigned SEC_CYC    = mad_pkg::SEC_CYCLES, // Cycles a second
   parameter int unsigned DIAL_WORDS = 16                   // Dial buffer
) (
   input  wire logic                 clk,         // 50 MHz clock
   input  wire logic                 resetn,      // Sync reset, low
   input  wire logic                 psel,        // APB select
   input  wire logic                 penable,     // APB access phase
   input  wire logic                 pwrite,      // APB direction
   input  wire logic [11:0]          paddr,       // APB byte address
   input  wire logic [31:0]          pwdata,      // APB write data
   output logic      [31:0]          prdata,      // APB read data
   output logic                      pready,      // APB ready
   output logic                      pslverr,     // APB error
   input  wire logic                 carrier,     // Modem carrier up
   input  wire logic                 dialFail,    // Modem dial failed
   input  wire logic                 charSeen,    // Char sent or received
   input  wire logic                 dialReady,   // Modem takes dial char
   output logic                      dialValid,   // Dial char valid
   output logic      [7:0]           dialChar,    // Dial char
   output logic                      xferReq,     // Run transfer command
   input  wire logic                 xferDone,    // Transfer finished
   output mad_pkg::madModemCtl_s     modemCtl     // Modem control lines
);

   localparam int unsigned IDXW = $clog2(2 * DIAL_WORDS);
   localparam logic [31:0] PAUSE_CYC =
      32'(mad_pkg::COMMA_PAUSE_S * SEC_CYC);
   localparam logic [31:0] SEC_LAST = 32'(SEC_CYC - 1);
   localparam logic [IDXW-1:0] IDX_LAST = IDXW'(2 * DIAL_WORDS - 1);

   // ==========================================================
   // Registers
   mad_pkg::madState_e state_q;
   logic [15:0] cmdCode_q, cmdConn_q, cmdTmo_q, errCode_q;
   logic [15:0] tblSig_q, tblRing_q, tblAuto_q, tblOpt_q, tblHup_q;
   logic [15:0] tblDtmo_q, connOpt_q, connNum_q;
   logic [15:0] dialStr_q [DIAL_WORDS];
   logic        errFlag_q, done_q, created_q, offHook_q;
   logic [31:0] secCnt_q, pauseCnt_q;
   logic [16:0] tmoSecs_q;
   logic [15:0] idleSecs_q;
   logic [IDXW-1:0] charIdx_q;

   // ==========================================================
   // Bus decode
   logic apbWr, mapped, dialSel, trig, errAck, secTick;
   logic [IDXW-2:0] dialWordIdx;
   assign apbWr  = psel && penable && pwrite;
   assign pready = 1'b1;
   assign dialSel = (paddr >= mad_pkg::REG_DIAL_STR) &&
      (paddr < mad_pkg::REG_DIAL_STR + 12'(4 * DIAL_WORDS));
   assign dialWordIdx = paddr[IDXW:2];
   assign trig   = apbWr && (paddr == mad_pkg::REG_CMD_TRIG) && pwdata[0];
   assign errAck = apbWr && (paddr == mad_pkg::REG_CMD_TRIG) && pwdata[1];
   assign secTick = (secCnt_q == SEC_LAST);

   always_comb begin
      mapped = 1'b1;
      prdata = mad_pkg::RESET_WORD;
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else if (paddr == mad_pkg::REG_CMD_CODE) begin
         prdata = {16'h0000, cmdCode_q};
      end else if (paddr == mad_pkg::REG_CMD_CONN) begin
         prdata = {16'h0000, cmdConn_q};
      end else if (paddr == mad_pkg::REG_CMD_TMO) begin
         prdata = {16'h0000, cmdTmo_q};
      end else if (paddr == mad_pkg::REG_CMD_TRIG) begin
         prdata = mad_pkg::RESET_WORD;
      end else if (paddr == mad_pkg::REG_CMD_ERR) begin
         prdata = {16'h0000, errCode_q};
      end else if (paddr == mad_pkg::REG_STATUS) begin
         prdata = {18'h00000, state_q, 3'b000, created_q, offHook_q,
                   errFlag_q, done_q, (state_q != mad_pkg::ST_IDLE &&
                   state_q != mad_pkg::ST_LINE)};
      end else if (paddr == mad_pkg::REG_TBL_SIG) begin
         prdata = {16'h0000, tblSig_q};
      end else if (paddr == mad_pkg::REG_TBL_RING) begin
         prdata = {16'h0000, tblRing_q};
      end else if (paddr == mad_pkg::REG_TBL_AUTO) begin
         prdata = {16'h0000, tblAuto_q};
      end else if (paddr == mad_pkg::REG_TBL_OPT) begin
         prdata = {16'h0000, tblOpt_q};
      end else if (paddr == mad_pkg::REG_TBL_HUP) begin
         prdata = {16'h0000, tblHup_q};
      end else if (paddr == mad_pkg::REG_TBL_DTMO) begin
         prdata = {16'h0000, tblDtmo_q};
      end else if (paddr == mad_pkg::REG_CONN_OPT) begin
         prdata = {16'h0000, connOpt_q};
      end else if (dialSel) begin
         prdata = {16'h0000, dialStr_q[dialWordIdx]};
      end else begin
         mapped = 1'b0;
      end
   end
   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Software-written configuration
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmdCode_q <= 16'h0000;
         cmdConn_q <= 16'h0000;
         cmdTmo_q  <= 16'h0000;
         tblSig_q  <= 16'h0000;
         tblRing_q <= 16'h0000;
         tblAuto_q <= 16'h0000;
         tblOpt_q  <= 16'h0000;
         tblHup_q  <= 16'h0000;
         tblDtmo_q <= 16'h0000;
         connOpt_q <= 16'h0000;
      end else if (apbWr) begin
         if (paddr == mad_pkg::REG_CMD_CODE) cmdCode_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_CMD_CONN) cmdConn_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_CMD_TMO) cmdTmo_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_SIG) tblSig_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_RING) tblRing_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_AUTO) tblAuto_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_OPT) tblOpt_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_HUP) tblHup_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_TBL_DTMO) tblDtmo_q <= pwdata[15:0];
         else if (paddr == mad_pkg::REG_CONN_OPT) connOpt_q <= pwdata[15:0];
      end
   end

   // Two characters a word, first one in the high byte
   generate
      for (genvar w = 0; w < DIAL_WORDS; w++) begin : gDial
         always_ff @(posedge clk) begin
            if (!resetn) begin
               dialStr_q[w] <= 16'h0000;
            end else if (apbWr && dialSel && dialWordIdx == (IDXW-1)'(w)) begin
               dialStr_q[w] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Derived configuration
   logic        modemOn, autoDial, hupOn;
   logic [16:0] dialTmo, cmdTmo;
   logic [7:0]  curChar;
   logic [15:0] curWord;
   assign modemOn  = (connOpt_q == mad_pkg::OPT_MODEM);
   assign autoDial = (tblAuto_q != 16'h0000);
   assign hupOn    = (tblHup_q != 16'h0000);
   assign dialTmo  = {1'b0, (tblDtmo_q == 16'h0000) ?
                     mad_pkg::DIAL_TMO_DEF_S : tblDtmo_q};
   assign cmdTmo   = {1'b0, (cmdTmo_q == 16'h0000) ?
                     mad_pkg::CMD_TMO_DEF_S : cmdTmo_q};
   assign curWord  = dialStr_q[charIdx_q[IDXW-1:1]];
   assign curChar  = charIdx_q[0] ? curWord[7:0] : curWord[15:8];

   assign modemCtl.offHook    = offHook_q;
   assign modemCtl.pulseDial  = tblOpt_q[mad_pkg::OPT_PULSE_BIT];
   assign modemCtl.busyDetOff = tblOpt_q[mad_pkg::OPT_BUSY_OFF_BIT];
   assign modemCtl.toneDetOff = tblOpt_q[mad_pkg::OPT_TONE_OFF_BIT];
   // Auto answer only while on hook under modem control
   assign modemCtl.answerRings = (!modemOn || offHook_q) ? 4'h0 :
      (tblRing_q > 16'(mad_pkg::MAX_RINGS)) ? mad_pkg::MAX_RINGS :
      tblRing_q[3:0];

   assign dialValid = (state_q == mad_pkg::ST_DIAL) &&
      (curChar != mad_pkg::CHAR_QUOTE) && (curChar != mad_pkg::CHAR_COMMA);
   assign dialChar  = curChar;
   assign xferReq   = (state_q == mad_pkg::ST_XFER);

   // ==========================================================
   // Second prescaler, free running
   always_ff @(posedge clk) begin
      if (!resetn) secCnt_q <= 32'h0000_0000;
      else if (secTick) secCnt_q <= 32'h0000_0000;
      else secCnt_q <= secCnt_q + 32'h0000_0001;
   end

   // Inactivity timer; only runs while a line is held with no command
   always_ff @(posedge clk) begin
      if (!resetn) idleSecs_q <= 16'h0000;
      else if (charSeen || state_q != mad_pkg::ST_LINE)
         idleSecs_q <= 16'h0000;
      else if (secTick && idleSecs_q != 16'hffff)
         idleSecs_q <= idleSecs_q + 16'h0001;
   end

   // ==========================================================
   // Command sequencing
   logic        tmoHit, hupHit, failNow;
   assign tmoHit  = secTick && (tmoSecs_q <= 17'h00001);
   assign hupHit  = hupOn && (idleSecs_q >= tblHup_q);
   assign failNow = dialFail || tmoHit;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q    <= mad_pkg::ST_IDLE;
         offHook_q  <= 1'b0;
         created_q  <= 1'b0;
         connNum_q  <= 16'h0000;
         tmoSecs_q  <= 17'h00000;
         charIdx_q  <= '0;
         pauseCnt_q <= 32'h0000_0000;
      end else begin
         if (secTick && tmoSecs_q != 17'h00000)
            tmoSecs_q <= tmoSecs_q - 17'h00001;
         case (state_q)
            mad_pkg::ST_IDLE, mad_pkg::ST_LINE: begin
               // A pending error blocks retry until acknowledged
               if (trig && !errFlag_q) begin
                  if (cmdCode_q == mad_pkg::CMD_CREATE) begin
                     if (!(modemOn && tblSig_q != mad_pkg::SIGNATURE)) begin
                        created_q <= 1'b1;
                        connNum_q <= cmdConn_q;
                     end
                  end else if (cmdCode_q == mad_pkg::CMD_HANGUP) begin
                     if (created_q && cmdConn_q == connNum_q) begin
                        offHook_q <= 1'b0;
                        state_q   <= mad_pkg::ST_IDLE;
                     end
                  end else if (cmdCode_q == mad_pkg::CMD_WRITE &&
                               created_q && cmdConn_q == connNum_q) begin
                     if (state_q == mad_pkg::ST_LINE || !modemOn) begin
                        tmoSecs_q <= cmdTmo;
                        state_q   <= mad_pkg::ST_XFER;
                     end else if (autoDial) begin
                        tmoSecs_q <= dialTmo + cmdTmo;
                        offHook_q <= 1'b1;
                        charIdx_q <= IDXW'(1); // Skip opening quote
                        state_q   <= mad_pkg::ST_DIAL;
                     end
                  end
               end else if (state_q == mad_pkg::ST_LINE && hupHit) begin
                  offHook_q <= 1'b0;
                  state_q   <= mad_pkg::ST_IDLE;
               end else if (state_q == mad_pkg::ST_LINE && !carrier) begin
                  offHook_q <= 1'b0;
                  state_q   <= mad_pkg::ST_IDLE;
               end
            end
            mad_pkg::ST_DIAL: begin
               if (failNow) begin
                  offHook_q <= 1'b0;
                  state_q   <= mad_pkg::ST_IDLE;
               end else if (curChar == mad_pkg::CHAR_QUOTE ||
                            charIdx_q == IDX_LAST) begin
                  state_q <= mad_pkg::ST_WAITC;
               end else if (curChar == mad_pkg::CHAR_COMMA) begin
                  pauseCnt_q <= PAUSE_CYC;
                  state_q    <= mad_pkg::ST_PAUSE;
               end else if (dialReady) begin
                  charIdx_q <= charIdx_q + IDXW'(1);
               end
            end
            mad_pkg::ST_PAUSE: begin
               if (failNow) begin
                  offHook_q <= 1'b0;
                  state_q   <= mad_pkg::ST_IDLE;
               end else if (pauseCnt_q <= 32'h0000_0001) begin
                  charIdx_q <= charIdx_q + IDXW'(1);
                  state_q   <= mad_pkg::ST_DIAL;
               end else begin
                  pauseCnt_q <= pauseCnt_q - 32'h0000_0001;
               end
            end
            mad_pkg::ST_WAITC: begin
               if (failNow) begin
                  offHook_q <= 1'b0;
                  state_q   <= mad_pkg::ST_IDLE;
               end else if (carrier) begin
                  state_q <= mad_pkg::ST_XFER;
               end
            end
            mad_pkg::ST_XFER: begin
               if (xferDone || tmoHit) begin
                  state_q <= offHook_q ? mad_pkg::ST_LINE : mad_pkg::ST_IDLE;
               end
            end
            default: state_q <= mad_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Error word, error flag and done flag
   logic        errEv, okEv;
   logic [15:0] errVal;
   always_comb begin
      errEv  = 1'b0;
      okEv   = 1'b0;
      errVal = 16'h0000;
      if ((state_q == mad_pkg::ST_IDLE || state_q == mad_pkg::ST_LINE) &&
          trig && !errFlag_q) begin
         if (cmdCode_q == mad_pkg::CMD_CREATE) begin
            errEv  = modemOn && (tblSig_q != mad_pkg::SIGNATURE);
            errVal = mad_pkg::ERR_BAD_SIG;
            okEv   = !errEv;
         end else if (cmdCode_q != mad_pkg::CMD_WRITE &&
                      cmdCode_q != mad_pkg::CMD_HANGUP) begin
            errEv  = 1'b1;
            errVal = mad_pkg::ERR_BAD_CMD;
         end else if (!created_q || cmdConn_q != connNum_q) begin
            errEv  = 1'b1;
            errVal = mad_pkg::ERR_BAD_CONN;
         end else if (cmdCode_q == mad_pkg::CMD_HANGUP) begin
            okEv = 1'b1;
         end else if (state_q == mad_pkg::ST_IDLE && modemOn && !autoDial) begin
            errEv  = 1'b1;
            errVal = mad_pkg::ERR_NO_LINE;
         end
      end else if ((state_q == mad_pkg::ST_DIAL ||
                    state_q == mad_pkg::ST_PAUSE ||
                    state_q == mad_pkg::ST_WAITC) && failNow) begin
         errEv  = 1'b1;
         errVal = mad_pkg::ERR_DIAL_FAIL;
      end else if (state_q == mad_pkg::ST_XFER) begin
         errEv  = tmoHit && !xferDone;
         errVal = mad_pkg::ERR_CMD_TMO;
         okEv   = xferDone;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         errCode_q <= 16'h0000;
         errFlag_q <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         // Hardware code wins over a software write in the same cycle
         if (errEv) errCode_q <= errVal;
         else if (apbWr && paddr == mad_pkg::REG_CMD_ERR)
            errCode_q <= pwdata[15:0];
         if (errEv) errFlag_q <= 1'b1;
         else if (errAck) errFlag_q <= 1'b0;
         if (okEv) done_q <= 1'b1;
         else if (trig) done_q <= 1'b0;
      end
   end

endmodule : mad_autodial

`default_nettype wire

// File: dv/mad_autodial_sva.sv
/* Port checker for the auto-dial command handler.
   Bound to mad_autodial below; sees that module's ports only. */
`timescale 1ns/100ps
`default_nettype none
module mad_autodial_sva (
   input wire logic                  clk,       // Clock
   input wire logic                  resetn,    // Sync reset
   input wire logic                  psel,      // APB select
   input wire logic                  penable,   // APB access
   input wire logic                  pwrite,    // APB write
   input wire logic [11:0]           paddr,     // APB address
   input wire logic [31:0]           pwdata,    // APB data
   input wire logic                  dialFail,  // Dial failed
   input wire logic                  dialValid, // Digit valid
   input wire logic [7:0]            dialChar,  // Digit
   input wire logic                  xferReq,   // Transfer run
   input wire logic                  xferDone,  // Transfer end
   input wire mad_pkg::madModemCtl_s modemCtl   // Modem lines
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Assertions
   ring_range_a: assert property (modemCtl.answerRings <= 4'h9)
      else $error("ring count above nine");
   ring_hook_a: assert property (modemCtl.offHook
      |-> modemCtl.answerRings == 4'h0) else $error("rings while off hook");
   opt_bits_a: assert property (psel && penable && pwrite
      && paddr == mad_pkg::REG_TBL_OPT |=> {modemCtl.busyDetOff,
      modemCtl.toneDetOff, modemCtl.pulseDial} == $past(pwdata[2:0]))
      else $error("option bits not applied");
   dial_hook_a: assert property (dialValid |-> modemCtl.offHook)
      else $error("digit offered on hook");
   dial_char_a: assert property (dialValid |->
      dialChar != mad_pkg::CHAR_QUOTE && dialChar != mad_pkg::CHAR_COMMA)
      else $error("quote or comma offered as digit");
   comma_pause_a: assert property ($fell(dialValid)
      && dialChar == mad_pkg::CHAR_COMMA |-> (!dialValid) [*8])
      else $error("no pause at comma");
   fail_hook_a: assert property (dialFail && modemCtl.offHook
      && !xferReq |=> !modemCtl.offHook) else $error("line kept after fail");
   xfer_end_a: assert property (xferReq && xferDone
      |=> !xferReq && modemCtl.offHook) else $error("transfer end wrong");
endmodule : mad_autodial_sva
bind mad_autodial mad_autodial_sva chk_u (.*);
`default_nettype wire

// File: dv/mad_modem_model.sv
/* Behavioural dial-up modem on the far side of the handler.
   In modes 0 and 1 ends dialing after 50 quiet cycles, longer than a comma pause. */
`timescale 1ns/100ps
`default_nettype none
module mad_modem_model (
   input  wire logic       clk,       // Clock
   input  wire logic       resetn,    // Sync reset
   input  wire logic       offHook,   // Line seized
   input  wire logic       dialValid, // Digit offered
   input  wire logic       xferReq,   // Transfer run
   input  wire logic [1:0] mode,      // 0 answer, 1 busy, 2 silent
   input  wire logic       slow,      // Take digits every other cycle
   output var logic        carrier,   // Connected
   output var logic        dialFail,  // Busy reported
   output var logic        charSeen,  // Char on line
   output var logic        dialReady, // Digit taken
   output var logic        xferDone   // Transfer end
);
   int dig, quiet, xc;
   initial {carrier, dialFail, charSeen, dialReady, xferDone} = '0;
   always @(posedge clk) begin
      dialReady <= resetn && (slow ? !dialReady : 1'b1);
      quiet <= dialValid ? 0 : quiet + 1;
      dig <= !offHook ? 0 : dig + 32'(dialValid && dialReady);
      // Carrier is lost as soon as the line is released
      carrier <= resetn && offHook && (carrier || (mode == 2'd0
         && dig > 0 && quiet == 50));
      dialFail <= resetn && offHook && mode == 2'd1 && dig > 0 && quiet == 50;
      // Count runs on into the held line so one late char lands there
      xc <= (xferReq || (offHook && xc != 0 && xc < 64)) ? xc + 1 : 0;
      charSeen <= resetn && (xferReq ? xc[1:0] == 2'b00
         : xc == 40);
      xferDone <= resetn && xferReq && xc == 12;
   end
endmodule : mad_modem_model
`default_nettype wire

// File: dv/mad_autodial_tb_top.sv
/* Self-checking bench of the auto-dial command handler.
   Drives APB and the modem model; one second is S cycles. */
`timescale 1ns/100ps
`default_nettype none
module mad_autodial_tb_top;
   localparam int S = 20;
   logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, seed = 32'h67c52320;
   logic pready, pslverr, carrier, dialFail, charSeen, dialReady, e;
   logic dialValid, xferReq, xferDone;
   logic [7:0] dialChar, d0, d1, d2, q[$];
   logic [3:0] r;
   logic [1:0] mode = 2'd0;
   mad_pkg::madModemCtl_s modemCtl;
   int err_total = 0, n_checks = 0, idleCnt = 0, n;
   mad_autodial #(.SEC_CYC(S)) dut_u (.*);
   mad_modem_model mdl_u (.*, .offHook(modemCtl.offHook));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (dialValid === 1'b1 && dialReady === 1'b1) q.push_back(dialChar);
      idleCnt <= (charSeen === 1'b1) ? 0 : idleCnt + 1;
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic inRange(int v, int lo, int hi);
      return v >= lo && v <= hi;
   endfunction : inRange
   task automatic end_sim();
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         chk(0, 1);
         end_sim();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Waits for offHook (s=0) or xferReq (s=1) to reach v
   task automatic waitSig(input logic s, input logic v, output int c);
      for (c = 0; c < 3000; c++) begin
         @(posedge clk);
         if ((s ? xferReq : modemCtl.offHook) === v) return;
      end
      chk(0, 1);
      end_sim();
   endtask : waitSig
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, 0);
      apb(0, 12'h0fc, 0);
      chk(e, 1);
      for (int i = 0; i < 8; i++) begin
         apb(1, mad_pkg::REG_TBL_OPT, i);
         chk({modemCtl.busyDetOff, modemCtl.toneDetOff, modemCtl.pulseDial},
            i);
      end
      r = 4'(rnd() % 10);
      d0 = 8'(8'h30 + rnd() % 10);
      d1 = 8'(8'h30 + rnd() % 10);
      d2 = 8'(8'h30 + rnd() % 10);
      apb(1, mad_pkg::REG_TBL_SIG, mad_pkg::SIGNATURE);
      apb(1, mad_pkg::REG_TBL_RING, r);
      apb(1, mad_pkg::REG_CONN_OPT, mad_pkg::OPT_MODEM);
      apb(1, mad_pkg::REG_TBL_AUTO, 1);
      apb(1, mad_pkg::REG_TBL_HUP, 3);
      apb(1, mad_pkg::REG_DIAL_STR, {8'h22, d0});
      apb(1, mad_pkg::REG_DIAL_STR + 12'h4, {8'h2c, d1});
      apb(1, mad_pkg::REG_DIAL_STR + 12'h8, {d2, 8'h22});
      chk(modemCtl.answerRings, r);
      apb(1, mad_pkg::REG_CMD_CODE, mad_pkg::CMD_CREATE);
      apb(1, mad_pkg::REG_CMD_CONN, 16'h4b17);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, 0);
      apb(1, mad_pkg::REG_CMD_CODE, mad_pkg::CMD_WRITE);
      slow <= 1'(rnd());
      q.delete();
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      waitSig(0, 1, n);
      waitSig(0, 0, n);
      chk({8'(q.size()), q[0], q[1], q[2]}, {8'd3, d0, d1, d2});
      chk(inRange(idleCnt, 2 * S - 2, 3 * S + 4), 1);
      apb(0, mad_pkg::REG_STATUS, 0);
      chk(rd[1], 1);
      mode <= 2'd1;
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      waitSig(0, 1, n);
      waitSig(0, 0, n);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, mad_pkg::ERR_DIAL_FAIL);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      repeat (5) @(posedge clk);
      chk(modemCtl.offHook, 0);
      apb(1, mad_pkg::REG_CMD_TRIG, 2);
      apb(1, mad_pkg::REG_CMD_ERR, 0);
      mode <= 2'd2;
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      waitSig(0, 1, n);
      waitSig(0, 0, n);
      chk(inRange(n, 38 * S - 2, 39 * S + 4), 1);
      apb(1, mad_pkg::REG_CMD_TRIG, 2);
      apb(1, mad_pkg::REG_CMD_ERR, 0);
      apb(1, mad_pkg::REG_TBL_HUP, 0);
      mode <= 2'd0;
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      waitSig(1, 1, n);
      waitSig(1, 0, n);
      repeat (4 * S) @(posedge clk);
      chk(modemCtl.offHook, 1);
      apb(1, mad_pkg::REG_CMD_CODE, mad_pkg::CMD_HANGUP);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      repeat (2) @(posedge clk);
      chk(modemCtl.offHook, 0);
      apb(1, mad_pkg::REG_CMD_CONN, 16'h4b18);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, mad_pkg::ERR_BAD_CONN);
      apb(1, mad_pkg::REG_CMD_TRIG, 2);
      apb(1, mad_pkg::REG_CMD_CODE, 16'h0401);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, mad_pkg::ERR_BAD_CMD);
      apb(1, mad_pkg::REG_CMD_TRIG, 2);
      apb(1, mad_pkg::REG_TBL_SIG, 0);
      apb(1, mad_pkg::REG_CMD_CODE, mad_pkg::CMD_CREATE);
      apb(1, mad_pkg::REG_CMD_TRIG, 1);
      apb(0, mad_pkg::REG_CMD_ERR, 0);
      chk(rd, mad_pkg::ERR_BAD_SIG);
      end_sim();
   end
endmodule : mad_autodial_tb_top
`default_nettype wire
